// [logic/wdt_params.svh]
// register map, field positions, reset values and timing counts
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_OFF_CTRL     8'h00
`define WDT_OFF_CLKSEL   8'h04
`define WDT_OFF_TA       8'h08
`define WDT_OFF_STAT     8'h0c
`define WDT_OFF_MASK     8'h10
`define WDT_OFF_IEN      8'h14
`define WDT_HSIZE_WORD   3'b010

`define WDT_B_POR        6
`define WDT_B_TIMEOUT_FLAG       3
`define WDT_B_WD_RESET_CAUSE_FLAG       2
`define WDT_B_EWT        1
`define WDT_B_RWT        0
`define WDT_B_SEL_HI     7
`define WDT_B_SEL_LO     6
`define WDT_B_IE         0
`define WDT_B_EA         1
`define WDT_S_TOUT       0
`define WDT_S_WRST       1

`define WDT_RST_POR      1'b1
`define WDT_RST_SEL      2'b00
`define WDT_RST_MASK     2'b00

`define WDT_TA_KEY1      8'haa
`define WDT_TA_KEY2      8'h55
`define WDT_TA_WIN       4'h8
`define WDT_RST_DLY      10'h200
`define WDT_MC_CLKS      4'h4
`define WDT_RST_MCYC     4'h2
`define WDT_RST_LEN      (`WDT_MC_CLKS * `WDT_RST_MCYC)

`endif

// [logic/wdt_pkg.sv]
// types shared by the watchdog modules
package wdt_pkg;
   typedef logic [1:0] wdt_sel_t;
   typedef enum logic [1:0] {WDT_TA_LOCKED, WDT_TA_KEYED, WDT_TA_OPEN}
      wdt_ta_state_t;
   typedef enum logic [1:0] {WDT_CT_RUN, WDT_CT_PEND, WDT_CT_RESET}
      wdt_ct_state_t;
endpackage : wdt_pkg

// [logic/wdt_cnt_if.sv]
// control/status link between register file and divider chain
`timescale 1ns/1ps
interface wdt_cnt_if;
   logic             restart;
   wdt_pkg::wdt_sel_t sel;
   logic             rst_en;
   logic             timeout;
   logic             wd_rst;
   modport ctl (output restart, sel, rst_en, input timeout, wd_rst);
   modport cnt (input restart, sel, rst_en, output timeout, wd_rst);
endinterface : wdt_cnt_if

// [logic/wdt_counter.sv]
// divider chain, time-out detect, delayed watchdog reset pulse
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_counter #(
   parameter int CNT_W = 26,
   parameter int EXP0  = 17,
   parameter int EXP1  = 20,
   parameter int EXP2  = 23,
   parameter int EXP3  = 26
) (
   input wire logic clk,
   input wire logic rst_n,
   wdt_cnt_if.cnt   cif
);
   import wdt_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [9:0]       dly_q;
   logic [3:0]       len_q;
   logic             tout_q;
   logic             wdr_q;
   wdt_ct_state_t    st_q;
   logic             hit;

   function automatic logic [CNT_W-1:0] last_count(wdt_sel_t s);
      int e;
      case (s)
         2'b00:   e = EXP0;
         2'b01:   e = EXP1;
         2'b10:   e = EXP2;
         default: e = EXP3;
      endcase
      return {CNT_W{1'b1}} >> (CNT_W - e);
   endfunction : last_count

   assign hit = !cif.restart && (cnt_q == last_count(cif.sel));
   assign cif.timeout = tout_q;
   assign cif.wd_rst  = wdr_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (cif.restart || hit) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tout_q <= 1'b0;
      end else begin
         tout_q <= hit;
      end
   end

   // a restart during the 512-clock grace period cancels the reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= WDT_CT_RUN;
         dly_q <= '0;
         len_q <= '0;
         wdr_q <= 1'b0;
      end else begin
         case (st_q)
            WDT_CT_RUN: begin
               if (hit && cif.rst_en) begin
                  st_q  <= WDT_CT_PEND;
                  dly_q <= '0;
               end
            end
            WDT_CT_PEND: begin
               if (cif.restart) begin
                  st_q <= WDT_CT_RUN;
               end else if (dly_q == `WDT_RST_DLY - 10'h001) begin
                  st_q  <= WDT_CT_RESET;
                  wdr_q <= 1'b1;
                  len_q <= '0;
               end else begin
                  dly_q <= dly_q + 10'h001;
               end
            end
            WDT_CT_RESET: begin
               if (len_q == `WDT_RST_LEN - 4'h1) begin
                  st_q  <= WDT_CT_RUN;
                  wdr_q <= 1'b0;
               end else begin
                  len_q <= len_q + 4'h1;
               end
            end
            default: st_q <= WDT_CT_RUN;
         endcase
      end
   end

   a_rst_delay: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(wdr_q) |-> $past(tout_q, 512)) else $error("reset not 512 late");
   a_rst_length: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(wdr_q) |-> wdr_q[*8] ##1 !wdr_q) else $error("bad reset length");
   a_restart_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      cif.restart |=> cnt_q == '0) else $error("restart kept count");
   a_timeout_point: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(tout_q) |-> $past(cnt_q) == last_count($past(cif.sel)))
      else $error("time-out at wrong count");
   c_wd_reset: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(wdr_q));
endmodule : wdt_counter

// [logic/wdt_top.sv]
// watchdog timer with AHB-Lite register slave and interrupt
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_top #(
   parameter int EXP0 = 17,
   parameter int EXP1 = 20,
   parameter int EXP2 = 23,
   parameter int EXP3 = 26
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        ext_reset,
   input  wire logic        pwr_fail,
   output logic             irq,
   output logic             wd_irq_req,
   output logic             wd_sys_rst
);
   import wdt_pkg::*;

   wdt_cnt_if cif ();

   logic          acc;
   logic          rd_stat;
   logic          wr_pend_q;
   logic [7:0]    wr_addr_q;
   logic [31:0]   hrdata_q;
   logic          hreadyout_q;
   logic          hresp_q;
   logic [7:0]    wdata;
   logic          wr_ctl;
   logic          wr_ctl_prot;
   logic          wr_ta;
   wdt_ta_state_t ta_st_q;
   logic [3:0]    ta_cnt_q;
   logic          ta_open;
   logic          por_q;
   logic          ewt_q;
   logic          timeout_flag_q;
   logic          wd_reset_cause_flag_q;
   logic          rwt_q;
   wdt_sel_t      sel_q;
   logic          ie_q;
   logic          ea_q;
   logic [1:0]    stat_q;
   logic [1:0]    mask_q;
   logic [1:0]    ev;
   logic          wdr_prev_q;
   logic          wdr_rise;
   logic          irq_q;
   logic          wd_irq_req_q;

   function automatic logic reg_hit(logic [7:0] a, logic [7:0] off);
      return a == off;
   endfunction : reg_hit

   function automatic logic [7:0] read_mux(logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (reg_hit(a, `WDT_OFF_CTRL)) begin
         // restart bit always reads zero
         r[`WDT_B_POR]  = por_q;
         r[`WDT_B_TIMEOUT_FLAG] = timeout_flag_q;
         r[`WDT_B_WD_RESET_CAUSE_FLAG] = wd_reset_cause_flag_q;
         r[`WDT_B_EWT]  = ewt_q;
      end else if (reg_hit(a, `WDT_OFF_CLKSEL)) begin
         r[`WDT_B_SEL_HI:`WDT_B_SEL_LO] = sel_q;
      end else if (reg_hit(a, `WDT_OFF_STAT)) begin
         r[1:0] = stat_q;
      end else if (reg_hit(a, `WDT_OFF_MASK)) begin
         r[1:0] = mask_q;
      end else if (reg_hit(a, `WDT_OFF_IEN)) begin
         r[`WDT_B_IE] = ie_q;
         r[`WDT_B_EA] = ea_q;
      end
      return r;
   endfunction : read_mux

   // zero-wait slave: address phase accepted whenever hready is high
   assign acc     = hsel && hready && htrans[1];
   assign rd_stat = acc && !hwrite && (haddr[31:8] == 24'h00_0000)
                    && reg_hit(haddr[7:0], `WDT_OFF_STAT);
   assign wdata   = hwdata[7:0];
   assign wr_ctl  = wr_pend_q && reg_hit(wr_addr_q, `WDT_OFF_CTRL);
   assign wr_ta   = wr_pend_q && reg_hit(wr_addr_q, `WDT_OFF_TA);
   assign ta_open = (ta_st_q == WDT_TA_OPEN);
   assign wr_ctl_prot = wr_ctl && ta_open;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         // non-word or out-of-range writes complete but store nothing
         wr_pend_q <= acc && hwrite && (hsize == `WDT_HSIZE_WORD)
                      && (haddr[31:8] == 24'h00_0000);
         if (acc) begin
            wr_addr_q <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (acc && !hwrite) begin
         if (haddr[31:8] == 24'h00_0000) begin
            hrdata_q <= {24'h00_0000, read_mux(haddr[7:0])};
         end else begin
            hrdata_q <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b0;
         hresp_q     <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end
   end

   // unlock: AAh then 55h, window then closes on its own
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ta_st_q  <= WDT_TA_LOCKED;
         ta_cnt_q <= 4'h0;
      end else begin
         case (ta_st_q)
            WDT_TA_LOCKED: begin
               if (wr_ta && wdata == `WDT_TA_KEY1) begin
                  ta_st_q <= WDT_TA_KEYED;
               end
            end
            WDT_TA_KEYED: begin
               if (wr_ta && wdata == `WDT_TA_KEY2) begin
                  ta_st_q  <= WDT_TA_OPEN;
                  ta_cnt_q <= `WDT_TA_WIN - 4'h1;
               end else if (wr_pend_q) begin
                  ta_st_q <= WDT_TA_LOCKED;
               end
            end
            WDT_TA_OPEN: begin
               if (ta_cnt_q == 4'h0) begin
                  ta_st_q <= WDT_TA_LOCKED;
               end else begin
                  ta_cnt_q <= ta_cnt_q - 4'h1;
               end
            end
            default: ta_st_q <= WDT_TA_LOCKED;
         endcase
      end
   end

   // hresetn is the power-on reset: flag comes up set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         por_q <= `WDT_RST_POR;
      end else if (wr_ctl_prot) begin
         por_q <= wdata[`WDT_B_POR];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ewt_q <= 1'b0;
      end else if (pwr_fail) begin
         ewt_q <= 1'b0;
      end else if (wr_ctl_prot) begin
         ewt_q <= wdata[`WDT_B_EWT];
      end
   end

   // hardware set beats a same-cycle software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timeout_flag_q <= 1'b0;
      end else if (cif.timeout) begin
         timeout_flag_q <= 1'b1;
      end else if (wr_ctl_prot) begin
         timeout_flag_q <= wdata[`WDT_B_TIMEOUT_FLAG];
      end
   end

   // software may only clear the cause flag, never set it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wd_reset_cause_flag_q <= 1'b0;
      end else if (pwr_fail) begin
         wd_reset_cause_flag_q <= 1'b0;
      end else if (wdr_rise) begin
         wd_reset_cause_flag_q <= 1'b1;
      end else if (wr_ctl && !wdata[`WDT_B_WD_RESET_CAUSE_FLAG]) begin
         wd_reset_cause_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rwt_q <= 1'b0;
      end else begin
         rwt_q <= wr_ctl_prot && wdata[`WDT_B_RWT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_q <= `WDT_RST_SEL;
      end else if (wr_pend_q && reg_hit(wr_addr_q, `WDT_OFF_CLKSEL)) begin
         sel_q <= wdata[`WDT_B_SEL_HI:`WDT_B_SEL_LO];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ie_q <= 1'b0;
         ea_q <= 1'b0;
      end else if (wr_pend_q && reg_hit(wr_addr_q, `WDT_OFF_IEN)) begin
         ie_q <= wdata[`WDT_B_IE];
         ea_q <= wdata[`WDT_B_EA];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= `WDT_RST_MASK;
      end else if (wr_pend_q && reg_hit(wr_addr_q, `WDT_OFF_MASK)) begin
         mask_q <= wdata[1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdr_prev_q <= 1'b0;
      end else begin
         wdr_prev_q <= cif.wd_rst;
      end
   end

   assign wdr_rise = cif.wd_rst && !wdr_prev_q;

   always_comb begin
      ev               = 2'b00;
      ev[`WDT_S_TOUT]  = cif.timeout;
      ev[`WDT_S_WRST]  = wdr_rise;
   end

   // read clears, but an event in the same cycle survives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= 2'b00;
      end else begin
         stat_q <= (stat_q & ~{2{rd_stat}}) | ev;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   // request path needs no reset enable, reset path no interrupt enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wd_irq_req_q <= 1'b0;
      end else begin
         wd_irq_req_q <= timeout_flag_q && ie_q && ea_q;
      end
   end

   // the counter is held cleared while any restart source is active
   assign cif.restart = rwt_q || ext_reset || pwr_fail
                        || cif.wd_rst;
   assign cif.sel     = sel_q;
   assign cif.rst_en  = ewt_q;

   wdt_counter #(
      .CNT_W (EXP3),
      .EXP0  (EXP0),
      .EXP1  (EXP1),
      .EXP2  (EXP2),
      .EXP3  (EXP3)
   ) u_counter (
      .clk   (hclk),
      .rst_n (hresetn),
      .cif   (cif.cnt)
   );

   assign hreadyout  = hreadyout_q;
   assign hresp      = hresp_q;
   assign hrdata     = hrdata_q;
   assign irq        = irq_q;
   assign wd_irq_req = wd_irq_req_q;
   assign wd_sys_rst = cif.wd_rst;

   a_irq_gating: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wd_irq_req |-> $past(timeout_flag_q) && $past(ie_q) && $past(ea_q))
      else $error("interrupt request without enables");
   a_timeout_flag_sticky: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $fell(timeout_flag_q) |-> $past(wr_ctl_prot))
      else $error("time-out flag cleared without write");
   a_ewt_locked: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $rose(ewt_q) |-> $past(ta_open) && $past(wr_ctl))
      else $error("reset enable set while locked");
   a_wd_reset_cause_flag_cause: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $rose(wd_reset_cause_flag_q) |-> $past(cif.wd_rst) && !$past(wdr_prev_q))
      else $error("cause flag set without watchdog reset");
   a_pwr_fail_off: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pwr_fail |=> !ewt_q && !wd_reset_cause_flag_q)
      else $error("power fail left watchdog armed");
   a_window_open: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $rose(ta_open) |-> ta_open[*8] ##1 !ta_open)
      else $error("timed access window wrong length");
   c_timeout: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(timeout_flag_q));
   c_prot_write: cover property (@(posedge hclk) disable iff (!hresetn)
      wr_ctl_prot && wdata[`WDT_B_RWT]);
   c_irq: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(irq));
endmodule : wdt_top

// [test/watchdog_timer_unit_tb.sv]
// self-checking bench for the watchdog timer unit over its register bus
`timescale 1ns/1ps
`include "wdt_params.svh"
module watchdog_timer_unit_tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire logic   hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        ext_reset;
   logic        pwr_fail;
   logic        irq;
   logic        wd_irq_req;
   logic        wd_sys_rst;
   int          failures;
   int          n_tests;

   // single slave: its ready is the bus ready
   assign hready = hreadyout;

   // short exponents keep the run small: 16, 32, 64, 128 clocks
   wdt_top #(.EXP0(4), .EXP1(5), .EXP2(6), .EXP3(7)) dut (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .ext_reset (ext_reset),
      .pwr_fail  (pwr_fail),
      .irq       (irq),
      .wd_irq_req(wd_irq_req),
      .wd_sys_rst(wd_sys_rst)
   );

   always #4 hclk = ~hclk;

   task automatic print_verdict;
      if (failures == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic expire(input string what);
      failures++;
      $display("FAIL %0t: %s wait expired", $time, what);
      print_verdict();
   endtask : expire

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask : tick

   task automatic wait_rdy;
      int i;
      i = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         i++;
         if (i > 50) expire("bus");
         @(posedge hclk);
      end
   endtask : wait_rdy

   // one single word transfer; read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h00_0000, a};
      hwrite <= wr;
      hsize  <= `WDT_HSIZE_WORD;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      wait_rdy();
      q = hrdata;
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      logic [31:0] q;
      ahb(1'b0, a, 8'h00, q);
      chk(q & m, exp);
   endtask : rd_chk

   task automatic unlock_wr(input logic [7:0] d);
      wr(`WDT_OFF_TA, `WDT_TA_KEY1);
      wr(`WDT_OFF_TA, `WDT_TA_KEY2);
      wr(`WDT_OFF_CTRL, d);
   endtask : unlock_wr

   // edges until the chosen output is seen high: 0 irq, 1 req, 2 reset
   task automatic wait_hi(input int s, input int bound, output int n);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
         if (n > bound) expire("output");
      end while ((s == 0 ? irq : s == 1 ? wd_irq_req : wd_sys_rst) !== 1'b1);
   endtask : wait_hi

   // watches the reset output; optional external restart every 10 clocks
   task automatic quiet(input int cyc, input logic kick, output logic seen);
      seen = 1'b0;
      for (int i = 0; i < cyc; i++) begin
         @(posedge hclk);
         seen = seen | wd_sys_rst;
         ext_reset <= kick && (i % 10 == 0);
      end
      ext_reset <= 1'b0;
   endtask : quiet

   task automatic t_reset_values;
      rd_chk(`WDT_OFF_CTRL, 32'h0000_00ff, 32'h0000_0040);
      rd_chk(`WDT_OFF_CLKSEL, 32'h0000_00ff, 32'h0000_0000);
      rd_chk(`WDT_OFF_MASK, 32'hffff_ffff, 32'h0000_0000);
      rd_chk(`WDT_OFF_IEN, 32'hffff_ffff, 32'h0000_0000);
      wr(8'h40, 8'hff);
      chk(hresp, 1'b0);
      rd_chk(8'h40, 32'hffff_ffff, 32'h0000_0000);
      rd_chk(`WDT_OFF_TA, 32'hffff_ffff, 32'h0000_0000);
   endtask : t_reset_values

   task automatic t_protect;
      wr(`WDT_OFF_CTRL, 8'h02);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0042, 32'h0000_0040);
      wr(`WDT_OFF_TA, `WDT_TA_KEY1);
      wr(`WDT_OFF_CLKSEL, 8'h00);
      wr(`WDT_OFF_TA, `WDT_TA_KEY2);
      wr(`WDT_OFF_CTRL, 8'h02);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0042, 32'h0000_0040);
      unlock_wr(8'h42);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0042, 32'h0000_0042);
      wr(`WDT_OFF_TA, `WDT_TA_KEY1);
      wr(`WDT_OFF_TA, `WDT_TA_KEY2);
      tick(12);
      wr(`WDT_OFF_CTRL, 8'h00);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0042, 32'h0000_0042);
      unlock_wr(8'h00);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_00ff, 32'h0000_0000);
      unlock_wr(8'h40);
   endtask : t_protect

   task automatic t_interval;
      int n;
      int lo;
      logic [31:0] q;
      wr(`WDT_OFF_MASK, 8'h01);
      for (int s = 0; s < 4; s++) begin
         lo = 1 << (4 + s);
         ext_reset <= 1'b1;
         wr(`WDT_OFF_CLKSEL, 8'(s << 6));
         ahb(1'b0, `WDT_OFF_STAT, 8'h00, q);
         @(posedge hclk);
         ext_reset <= 1'b0;
         wait_hi(0, 300, n);
         chk(32'(n >= lo && n <= lo + 6), 32'h0000_0001);
      end
      // restart in mid-interval pushes the next time-out a full 128 on
      tick(90);
      unlock_wr(8'h41);
      rd_chk(`WDT_OFF_STAT, 32'h0000_0001, 32'h0000_0001);
      wait_hi(0, 300, n);
      chk(32'(n >= 122 && n <= 134), 32'h0000_0001);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0009, 32'h0000_0008);
      wr(`WDT_OFF_MASK, 8'h00);
      ahb(1'b0, `WDT_OFF_STAT, 8'h00, q);
      tick(140);
      chk(irq, 1'b0);
      rd_chk(`WDT_OFF_STAT, 32'h0000_0001, 32'h0000_0001);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0008, 32'h0000_0008);
   endtask : t_interval

   task automatic t_irq_gate;
      for (int e = 0; e < 4; e++) begin
         wr(`WDT_OFF_IEN, 8'(e));
         tick(3);
         chk(wd_irq_req, e == 3);
      end
      chk(wd_sys_rst, 1'b0);
   endtask : t_irq_gate

   task automatic t_reset_path;
      int n;
      int m;
      int k;
      logic seen;
      wr(`WDT_OFF_CLKSEL, 8'h00);
      unlock_wr(8'h43);
      tick(2);
      wait_hi(1, 100, n);
      wait_hi(2, 600, m);
      chk(32'(m >= 509 && m <= 511), 32'h0000_0001);
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (wd_sys_rst === 1'b1 && k < 20);
      chk(32'(k), 32'd8);
      tick(2);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0006, 32'h0000_0006);
      rd_chk(`WDT_OFF_STAT, 32'h0000_0002, 32'h0000_0002);
      wr(`WDT_OFF_CTRL, 8'h00);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0006, 32'h0000_0002);
      quiet(600, 1'b1, seen);
      chk(seen, 1'b0);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0002, 32'h0000_0002);
      wait_hi(2, 700, n);
      tick(12);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0004, 32'h0000_0004);
      pwr_fail <= 1'b1;
      tick(1);
      pwr_fail <= 1'b0;
      tick(2);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_0046, 32'h0000_0040);
      quiet(600, 1'b0, seen);
      chk(seen, 1'b0);
      unlock_wr(8'h42);
      hresetn <= 1'b0;
      tick(2);
      hresetn <= 1'b1;
      tick(2);
      rd_chk(`WDT_OFF_CTRL, 32'h0000_00ff, 32'h0000_0040);
   endtask : t_reset_path

   initial begin
      hclk      = 1'b0;
      hresetn   = 1'b0;
      hsel      = 1'b0;
      haddr     = 32'h0000_0000;
      htrans    = 2'b00;
      hwrite    = 1'b0;
      hsize     = 3'b000;
      hwdata    = 32'h0000_0000;
      ext_reset = 1'b0;
      pwr_fail  = 1'b0;
      failures  = 0;
      n_tests   = 0;
      tick(12);
      hresetn <= 1'b1;
      tick(2);
      t_reset_values();
      t_protect();
      t_interval();
      t_irq_gate();
      t_reset_path();
      print_verdict();
   end
endmodule : watchdog_timer_unit_tb
